// [hw/sac_pkg.sv]
// Purpose: shared constants for the converter conversion control block
// Assumes: 8-bit register port, 3-bit register address
// Notes:   offsets of all registers, field positions of control main, config and interrupt status
package sac_pkg;
    // register offsets
    localparam logic [2:0] ADDR_CONTROL_MAIN = 3'h0;
    localparam logic [2:0] ADDR_CONFIG       = 3'h1;
    localparam logic [2:0] ADDR_CHANNEL      = 3'h2;
    localparam logic [2:0] ADDR_RESULT_HIGH  = 3'h3;
    localparam logic [2:0] ADDR_RESULT_LOW   = 3'h4;
    localparam logic [2:0] ADDR_INT_STATUS   = 3'h5;
    localparam logic [2:0] ADDR_INT_MASK     = 3'h6;
    localparam logic [2:0] ADDR_POWERUP      = 3'h7;
    // control main fields
    localparam int SRC_LSB   = 0;
    localparam int BUSY_BIT  = 3;
    localparam int DLY_BIT   = 4;
    localparam int BURST_BIT = 5;
    localparam int PWR_BIT   = 6;
    localparam int DONE_BIT  = 7;
    // config fields
    localparam int DIV_LSB   = 0;
    localparam int RPT_LSB   = 5;
    // interrupt status bits
    localparam int ST_DONE   = 0;
    localparam int ST_OVRN   = 1;
    // start source codes
    localparam logic [1:0] SRC_SOFTWARE = 2'h0;
    localparam logic [1:0] SRC_TIMER    = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    // channel codes
    localparam logic [4:0] CH_TEMP = 5'h10;
    localparam logic [4:0] CH_NONE = 5'h14;
    // timing in conversion clocks
    localparam logic [7:0] TRACK_CLKS = 8'h04;
    // reset values
    localparam logic [7:0] RST_POWERUP = 8'h01;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    typedef enum logic [1:0] {ST_IDLE, ST_POWERUP, ST_TRACK, ST_CONVERT} sac_state_t;
endpackage

// [hw/sac_ctrl.sv]
// Purpose: conversion control for a successive-approximation converter
// Assumes: analog core answers each start with a done pulse and its data
// Notes:   external pins pass two flip-flops before use
//
// What this block does
// - channel codes 0..15 route P0.0-P0.7 then P1.0-P1.7 in order.
// - codes 16..19 pick temperature, regulator, supply, ground; higher codes none.
// - conversion clock divides system clock, or oscillator in burst mode.
// - start source is software busy write, timer overflow, or external rising edge.
// - start source comes from control register, no code needed for others.
// - completion posts result high/low registers and sets done flag.
// - done flag raises interrupt when enabled, else stays set for polling.
// - busy reads one during conversion and clears at completion.
// - default mode tracks continuously except while converting, starts at once.
// - delayed tracking with internal start tracks four conversion clocks first.
// - delayed tracking with external start tracks while low, converts on rise.
// - sixteen-bit accumulator sums successive results.
// - burst mode powers up, samples, accumulates and shuts down alone.
// - burst start runs repeat count conversions; starts during burst ignored.
// - done flag sets only after repeat count conversions accumulated.
// - burst powers down after burst unless enabled; waits power-up time.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
module sac_ctrl #(
    parameter int DATA_W = 12
) (
    input  wire logic              CLK_I,
    input  wire logic              RESET_N_I,
    input  wire logic [2:0]        ADDR_I,
    input  wire logic [7:0]        WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [7:0]        RDATA_O,
    input  wire logic              TIMER_OVF_I,
    input  wire logic              EXTERNAL_CONVERT_START_I,
    input  wire logic              HF_OSC_I,
    input  wire logic              SAR_DONE_I,
    input  wire logic [DATA_W-1:0] SAR_DATA_I,
    output logic                   CONVERSION_CLOCK_O,
    output logic                   SAR_START_O,
    output logic                   TRACK_O,
    output logic                   POWER_ON_O,
    output logic      [15:0]       PIN_SELECT_O,
    output logic      [3:0]        INTERNAL_SELECT_O,
    output logic                   IRQ_O
);
    // one-hot pin and internal source selection
    function automatic logic [19:0] chan_decode(input logic [4:0] code);
        logic [19:0] sel;
        sel = 20'h0_0000;
        if (code < sac_pkg::CH_NONE)
        begin
            sel[code] = 1'b1;
        end
        return sel;
    endfunction

    // repeat count from its code
    function automatic logic [6:0] rpt_count(input logic [2:0] code);
        logic [6:0] n;
        n = 7'h01;
        if (code != 3'h0 && code < 3'h6)
        begin
            n = 7'(7'h02 << code);
        end
        return n;
    endfunction

    logic [1:0]  src_sel, next_src_sel;
    logic        dly_trk, next_dly_trk;
    logic        burst_en, next_burst_en;
    logic        pwr_en, next_pwr_en;
    logic [4:0]  div, next_div;
    logic [2:0]  rpt_sel, next_rpt_sel;
    logic [4:0]  chan, next_chan;
    logic [7:0]  pwrup_time, next_pwrup_time;
    logic [1:0]  mask, next_mask;
    logic [1:0]  status, next_status;
    logic [15:0] result, next_result;
    logic [15:0] acc, next_acc;
    logic [6:0]  nconv, next_nconv;
    logic        busy, next_busy;
    logic [7:0]  cnt, next_cnt;
    logic [4:0]  div_cnt, next_div_cnt;
    logic        sar_clk, next_sar_clk;
    logic        sar_start, next_sar_start;
    logic        track, next_track;
    logic        power_on, next_power_on;
    logic [19:0] sel, next_sel;
    logic        irq, next_irq;
    logic [7:0]  rdata, next_rdata;
    logic        ext_s1, ext_s2, ext_s3;
    logic        hf_s1, hf_s2, hf_s3;
    sac_pkg::sac_state_t state, next_state;

    logic        sw_start, trig, src_tick, tick, ext_rise, hf_rise, go_seq, last;
    logic [15:0] acc_sum;
    logic [6:0]  rpt_n;

    assign ext_rise = ext_s2 && !ext_s3;
    assign hf_rise  = hf_s2 && !hf_s3;

    always_comb
    begin
        next_src_sel    = src_sel;
        next_dly_trk    = dly_trk;
        next_burst_en   = burst_en;
        next_pwr_en     = pwr_en;
        next_div        = div;
        next_rpt_sel    = rpt_sel;
        next_chan       = chan;
        next_pwrup_time = pwrup_time;
        next_mask       = mask;
        next_status     = status;
        next_result     = result;
        next_acc        = acc;
        next_nconv      = nconv;
        next_busy       = busy;
        next_cnt        = cnt;
        next_state      = state;
        next_sar_start  = 1'b0;
        next_rdata      = rdata;
        go_seq          = 1'b0;
        rpt_n           = rpt_count(rpt_sel);
        last            = (nconv + 7'h01) == rpt_n;
        acc_sum         = acc + 16'(SAR_DATA_I);
        // register writes, done flag write-one-to-clear
        if (WR_I)
        begin
            unique case (ADDR_I)
                sac_pkg::ADDR_CONTROL_MAIN:
                begin
                    next_src_sel  = WDATA_I[sac_pkg::SRC_LSB +: 2];
                    next_dly_trk  = WDATA_I[sac_pkg::DLY_BIT];
                    next_burst_en = WDATA_I[sac_pkg::BURST_BIT];
                    next_pwr_en   = WDATA_I[sac_pkg::PWR_BIT];
                    if (WDATA_I[sac_pkg::DONE_BIT])
                    begin
                        next_status[sac_pkg::ST_DONE] = 1'b0;
                    end
                end
                sac_pkg::ADDR_CONFIG:
                begin
                    next_div     = WDATA_I[sac_pkg::DIV_LSB +: 5];
                    next_rpt_sel = WDATA_I[sac_pkg::RPT_LSB +: 3];
                end
                sac_pkg::ADDR_CHANNEL:    next_chan = WDATA_I[4:0];
                sac_pkg::ADDR_INT_STATUS: next_status = status & ~WDATA_I[1:0];
                sac_pkg::ADDR_INT_MASK:   next_mask = WDATA_I[1:0];
                sac_pkg::ADDR_POWERUP:    next_pwrup_time = WDATA_I;
                default:                  next_mask = mask;
            endcase
        end
        src_tick     = burst_en ? hf_rise : 1'b1;
        tick         = src_tick && (div_cnt == div);
        next_div_cnt = src_tick ? (tick ? 5'h00 : div_cnt + 5'h01) : div_cnt;
        next_sar_clk = tick ? !sar_clk : sar_clk;
        sw_start = WR_I && (ADDR_I == sac_pkg::ADDR_CONTROL_MAIN) && WDATA_I[sac_pkg::BUSY_BIT];
        unique case (src_sel)
            sac_pkg::SRC_SOFTWARE: trig = sw_start;
            sac_pkg::SRC_TIMER:    trig = TIMER_OVF_I;
            sac_pkg::SRC_EXTERNAL: trig = ext_rise;
            default:               trig = 1'b0;
        endcase
        unique case (state)
            sac_pkg::ST_IDLE:
            begin
                if (trig)
                begin
                    next_busy = 1'b1;
                    if (burst_en && !pwr_en)
                    begin
                        next_state = sac_pkg::ST_POWERUP;
                        next_cnt   = 8'h00;
                    end
                    else
                    begin
                        go_seq = 1'b1;
                    end
                end
            end
            sac_pkg::ST_POWERUP:
            begin
                if (tick)
                begin
                    next_cnt = cnt + 8'h01;
                    go_seq   = (cnt + 8'h01) >= pwrup_time;
                end
            end
            sac_pkg::ST_TRACK:
            begin
                if (tick)
                begin
                    next_cnt = cnt + 8'h01;
                    if (cnt == sac_pkg::TRACK_CLKS - 8'h01)
                    begin
                        next_state     = sac_pkg::ST_CONVERT;
                        next_sar_start = 1'b1;
                    end
                end
            end
            sac_pkg::ST_CONVERT:
            begin
                if (SAR_DONE_I)
                begin
                    next_acc   = acc_sum;
                    next_nconv = nconv + 7'h01;
                    if (last)
                    begin
                        next_result                   = acc_sum;
                        next_acc                      = 16'h0000;
                        next_nconv                    = 7'h00;
                        next_status[sac_pkg::ST_DONE] = 1'b1;
                    end
                    if (burst_en && !last)
                    begin
                        go_seq = 1'b1;
                    end
                    else
                    begin
                        next_state = sac_pkg::ST_IDLE;
                        next_busy  = 1'b0;
                    end
                end
            end
        endcase
        if (go_seq)
        begin
            next_cnt = 8'h00;
            if (dly_trk && src_sel != sac_pkg::SRC_EXTERNAL)
            begin
                next_state = sac_pkg::ST_TRACK;
            end
            else
            begin
                next_state     = sac_pkg::ST_CONVERT;
                next_sar_start = 1'b1;
            end
        end
        // starts during a conversion ignored, noted as overrun
        if (trig && state != sac_pkg::ST_IDLE)
        begin
            next_status[sac_pkg::ST_OVRN] = 1'b1;
        end
        next_track = (next_state == sac_pkg::ST_TRACK)
                   || (next_state == sac_pkg::ST_IDLE
                       && (dly_trk ? (src_sel == sac_pkg::SRC_EXTERNAL && !ext_s2)
                                   : !burst_en));
        next_power_on = pwr_en || (next_state != sac_pkg::ST_IDLE);
        next_sel = chan_decode(chan);
        next_irq = |(next_status & next_mask);
        if (RD_I)
        begin
            unique case (ADDR_I)
                sac_pkg::ADDR_CONTROL_MAIN:
                    next_rdata = {status[sac_pkg::ST_DONE], pwr_en, burst_en, dly_trk,
                                  busy, 1'b0, src_sel};
                sac_pkg::ADDR_CONFIG:      next_rdata = {rpt_sel, div};
                sac_pkg::ADDR_CHANNEL:     next_rdata = {3'h0, chan};
                sac_pkg::ADDR_RESULT_HIGH: next_rdata = result[15:8];
                sac_pkg::ADDR_RESULT_LOW:  next_rdata = result[7:0];
                sac_pkg::ADDR_INT_STATUS:  next_rdata = {6'h00, status};
                sac_pkg::ADDR_INT_MASK:    next_rdata = {6'h00, mask};
                sac_pkg::ADDR_POWERUP:     next_rdata = pwrup_time;
                default:                   next_rdata = sac_pkg::RST_ZERO;
            endcase
        end
        else
        begin
            next_rdata = sac_pkg::RST_ZERO;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            src_sel    <= sac_pkg::SRC_SOFTWARE;
            dly_trk    <= 1'b0;
            burst_en   <= 1'b0;
            pwr_en     <= 1'b0;
            div        <= 5'h00;
            rpt_sel    <= 3'h0;
            chan       <= 5'h00;
            pwrup_time <= sac_pkg::RST_POWERUP;
            mask       <= 2'h0;
            status     <= 2'h0;
            result     <= 16'h0000;
            acc        <= 16'h0000;
            nconv      <= 7'h00;
            busy       <= 1'b0;
            cnt        <= 8'h00;
            div_cnt    <= 5'h00;
            sar_clk    <= 1'b0;
            sar_start  <= 1'b0;
            track      <= 1'b0;
            power_on   <= 1'b0;
            sel        <= 20'h0_0000;
            irq        <= 1'b0;
            rdata      <= sac_pkg::RST_ZERO;
            state      <= sac_pkg::ST_IDLE;
            ext_s1     <= 1'b0;
            ext_s2     <= 1'b0;
            ext_s3     <= 1'b0;
            hf_s1      <= 1'b0;
            hf_s2      <= 1'b0;
            hf_s3      <= 1'b0;
        end
        else
        begin
            src_sel    <= next_src_sel;
            dly_trk    <= next_dly_trk;
            burst_en   <= next_burst_en;
            pwr_en     <= next_pwr_en;
            div        <= next_div;
            rpt_sel    <= next_rpt_sel;
            chan       <= next_chan;
            pwrup_time <= next_pwrup_time;
            mask       <= next_mask;
            status     <= next_status;
            result     <= next_result;
            acc        <= next_acc;
            nconv      <= next_nconv;
            busy       <= next_busy;
            cnt        <= next_cnt;
            div_cnt    <= next_div_cnt;
            sar_clk    <= next_sar_clk;
            sar_start  <= next_sar_start;
            track      <= next_track;
            power_on   <= next_power_on;
            sel        <= next_sel;
            irq        <= next_irq;
            rdata      <= next_rdata;
            state      <= next_state;
            ext_s1     <= EXTERNAL_CONVERT_START_I;
            ext_s2     <= ext_s1;
            ext_s3     <= ext_s2;
            hf_s1      <= HF_OSC_I;
            hf_s2      <= hf_s1;
            hf_s3      <= hf_s2;
        end
    end

    assign RDATA_O            = rdata;
    assign CONVERSION_CLOCK_O = sar_clk;
    assign SAR_START_O        = sar_start;
    assign TRACK_O            = track;
    assign POWER_ON_O         = power_on;
    assign PIN_SELECT_O       = sel[15:0];
    assign INTERNAL_SELECT_O  = sel[19:16];
    assign IRQ_O              = irq;

    property p_busy_on_start;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        state == sac_pkg::ST_IDLE && trig |=> busy;
    endproperty
    a_busy_on_start: assert property (p_busy_on_start) else $error("busy not set");

    property p_done_post;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        state == sac_pkg::ST_CONVERT && SAR_DONE_I && last
        |=> status[sac_pkg::ST_DONE] && result == $past(acc_sum);
    endproperty
    a_done_post: assert property (p_done_post) else $error("result not posted");

    property p_no_early_done;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        !status[sac_pkg::ST_DONE] && !(state == sac_pkg::ST_CONVERT && SAR_DONE_I && last)
        |=> !status[sac_pkg::ST_DONE];
    endproperty
    a_no_early_done: assert property (p_no_early_done) else $error("early done");

    property p_track_four;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        state == sac_pkg::ST_TRACK && tick && cnt == 8'h03
        |=> state == sac_pkg::ST_CONVERT && SAR_START_O;
    endproperty
    a_track_four: assert property (p_track_four) else $error("tracking length wrong");

    property p_edge_once;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        ext_rise |=> !ext_rise;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge seen twice");

    property p_irq_mask;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        ##1 IRQ_O == |(status & mask);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt mismatch");

    property p_ignore_busy;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        state != sac_pkg::ST_IDLE && trig |=> status[sac_pkg::ST_OVRN] && busy;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) else $error("start not ignored");

    property p_busy_clear;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        state == sac_pkg::ST_CONVERT && SAR_DONE_I && (!burst_en || last) |=> !busy;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy stuck");

    property p_powerup;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        state == sac_pkg::ST_IDLE && trig && burst_en && !pwr_en
        |=> state == sac_pkg::ST_POWERUP ##1 POWER_ON_O;
    endproperty
    a_powerup: assert property (p_powerup) else $error("no power-up wait");

    property p_no_route;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        chan >= sac_pkg::CH_NONE |=> PIN_SELECT_O == 16'h0000 && INTERNAL_SELECT_O == 4'h0;
    endproperty
    a_no_route: assert property (p_no_route) else $error("unconnected code routed");
endmodule

// [testbench/sac_sar_model.sv]
// Purpose: analog core stand-in answering each start with data
// Assumes: one start at a time, same clock as the control block
// Notes:   data line toggles between answers; values step by 0x011
module sac_sar_model (
    input  wire logic        clk_i,
    input  wire logic        start_i,
    input  wire logic        slow_i,
    output logic             done_o,
    output logic [11:0]      data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] value    = 12'h011;
    int          wait_cnt = 0;
    initial done_o = 1'b0;
    initial data_o = 12'h0a5;
    // answer after a short or long latency
    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        data_o <= ~data_o;
        if (start_i === 1'b1)
        begin
            wait_cnt <= slow_i ? 6 : 1;
        end
        else if (wait_cnt == 1)
        begin
            done_o   <= 1'b1;
            data_o   <= value;
            value    <= value + 12'h011;
            wait_cnt <= 0;
        end
        else if (wait_cnt > 1)
        begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

// [testbench/sar_adc_conversion_control_test.sv]
// Purpose: self-checking bench for the conversion control block
// Assumes: analog core model answers every start
// Notes:   one task per scenario, bus driven after rising edges
module sar_adc_conversion_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        tovf = 1'b0;
    logic        ext = 1'b0;
    logic        hf = 1'b0;
    logic        slow = 1'b1;
    logic [7:0]  rdata;
    logic        sdone;
    logic [11:0] sdata;
    logic        cclk;
    logic        sstart;
    logic        track;
    logic        pwr;
    logic [15:0] pins;
    logic [3:0]  isel;
    logic        irq;
    logic [15:0] acc = 16'h0000;
    logic [11:0] nxt = 12'h011;
    int          num_errors = 0;
    int          tests_run = 0;
    initial forever #2 clk = ~clk;
    initial forever #7.2 hf = ~hf;
    sac_ctrl DUT (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TIMER_OVF_I(tovf),
        .EXTERNAL_CONVERT_START_I(ext), .HF_OSC_I(hf), .SAR_DONE_I(sdone),
        .SAR_DATA_I(sdata), .CONVERSION_CLOCK_O(cclk), .SAR_START_O(sstart),
        .TRACK_O(track), .POWER_ON_O(pwr), .PIN_SELECT_O(pins),
        .INTERNAL_SELECT_O(isel), .IRQ_O(irq));
    sac_sar_model core (.clk_i(clk), .start_i(sstart), .slow_i(slow), .done_o(sdone),
        .data_o(sdata));
    task automatic stop_test();
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(n, {8'h00, e}, {8'h00, rdata});
    endtask
    task automatic wait_start(output int n);
        #1;
        for (n = 0; n < 300 && sstart !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        if (n == 300)
        begin
            num_errors++;
            stop_test();
        end
    endtask
    task automatic wait_sdone();
        int i;
        for (i = 0; i < 3000 && sdone !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        if (i == 3000)
        begin
            num_errors++;
            stop_test();
        end
        acc = acc + {4'h0, nxt};
        nxt = nxt + 12'h011;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        for (int a = 0; a < 8; a++)
            rd_chk("reset", a[2:0], a == 7 ? sac_pkg::RST_POWERUP : 8'h00);
        chk("idle_track", 16'h0001, {15'h0000, track});
    endtask
    task automatic t_channel();
        for (int c = 0; c < 32; c++)
        begin
            wr_reg(sac_pkg::ADDR_CHANNEL, c[7:0]);
            repeat (2) @(posedge clk);
            #1;
            chk("pins", c < 16 ? 16'h0001 << c : 16'h0000, pins);
            chk("internal", (c > 15 && c < 20) ? 16'h0001 << (c - 16) : 16'h0000,
                {12'h000, isel});
        end
    endtask
    task automatic t_clock();
        int flips;
        logic last;
        flips = 0;
        wr_reg(sac_pkg::ADDR_CONFIG, 8'h03);
        repeat (3) @(posedge clk);
        #1;
        last = cclk;
        repeat (16)
        begin
            @(posedge clk);
            #1;
            if (cclk !== last) flips++;
            last = cclk;
        end
        chk("clock_flips", 16'h0004, flips[15:0]);
        wr_reg(sac_pkg::ADDR_CONFIG, 8'h00);
    endtask
    task automatic t_software();
        acc = 16'h0000;
        wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h08);
        #1;
        chk("start_now", 16'h0001, {15'h0000, sstart});
        chk("track_off", 16'h0000, {15'h0000, track});
        rd_chk("busy_high", sac_pkg::ADDR_CONTROL_MAIN, 8'h08);
        wait_sdone();
        chk("irq_masked", 16'h0000, {15'h0000, irq});
        rd_chk("control_done", sac_pkg::ADDR_CONTROL_MAIN, 8'h80);
        rd_chk("status_done", sac_pkg::ADDR_INT_STATUS, 8'h01);
        rd_chk("result_high", sac_pkg::ADDR_RESULT_HIGH, acc[15:8]);
        rd_chk("result_low", sac_pkg::ADDR_RESULT_LOW, acc[7:0]);
        wr_reg(sac_pkg::ADDR_INT_MASK, 8'h03);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_on", 16'h0001, {15'h0000, irq});
        wr_reg(sac_pkg::ADDR_INT_STATUS, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_clear", 16'h0000, {15'h0000, irq});
    endtask
    task automatic t_timer();
        int n;
        acc = 16'h0000;
        wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h01);
        @(posedge clk);
        tovf <= 1'b1;
        @(posedge clk);
        tovf <= 1'b0;
        wait_start(n);
        chk("timer_start", 16'h0000, n[15:0]);
        @(posedge clk);
        tovf <= 1'b1;
        @(posedge clk);
        tovf <= 1'b0;
        wait_sdone();
        rd_chk("overrun", sac_pkg::ADDR_INT_STATUS, 8'h03);
        rd_chk("timer_low", sac_pkg::ADDR_RESULT_LOW, acc[7:0]);
        wr_reg(sac_pkg::ADDR_INT_STATUS, 8'h03);
    endtask
    task automatic t_delay();
        int n;
        acc = 16'h0000;
        wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h10);
        wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h18);
        #1;
        chk("dly_track", 16'h0001, {15'h0000, track});
        wait_start(n);
        chk("dly_ticks", 16'h0001, {15'h0000, n >= 4 && n <= 8});
        wait_sdone();
        wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h12);
        repeat (8) @(posedge clk);
        #1;
        chk("ext_wait", 16'h0003, {14'h0000, track, ~sstart});
        acc = 16'h0000;
        @(posedge clk);
        ext <= 1'b1;
        wait_start(n);
        chk("ext_rise", 16'h0001, {15'h0000, n <= 8});
        @(posedge clk);
        ext <= 1'b0;
        wait_sdone();
        rd_chk("ext_low", sac_pkg::ADDR_RESULT_LOW, acc[7:0]);
        wr_reg(sac_pkg::ADDR_INT_STATUS, 8'h03);
    endtask
    task automatic t_repeat();
        acc = 16'h0000;
        wr_reg(sac_pkg::ADDR_CONFIG, 8'h20);
        wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h08);
            wait_sdone();
            if (k < 3) rd_chk("early_done", sac_pkg::ADDR_INT_STATUS, 8'h00);
        end
        rd_chk("sum_done", sac_pkg::ADDR_INT_STATUS, 8'h01);
        rd_chk("sum_high", sac_pkg::ADDR_RESULT_HIGH, acc[15:8]);
        rd_chk("sum_low", sac_pkg::ADDR_RESULT_LOW, acc[7:0]);
        wr_reg(sac_pkg::ADDR_INT_STATUS, 8'h03);
    endtask
    task automatic t_burst();
        int n;
        acc = 16'h0000;
        wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h20);
        wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h28);
        wait_start(n);
        chk("burst_power", 16'h0001, {15'h0000, pwr});
        wr_reg(sac_pkg::ADDR_CONTROL_MAIN, 8'h28);
        repeat (4) wait_sdone();
        repeat (4) @(posedge clk);
        #1;
        chk("burst_off", 16'h0002, {14'h0000, irq, pwr});
        rd_chk("burst_status", sac_pkg::ADDR_INT_STATUS, 8'h03);
        rd_chk("burst_high", sac_pkg::ADDR_RESULT_HIGH, acc[15:8]);
        rd_chk("burst_low", sac_pkg::ADDR_RESULT_LOW, acc[7:0]);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_channel();
        t_clock();
        t_software();
        t_timer();
        t_delay();
        t_repeat();
        t_burst();
        stop_test();
    end
endmodule
